// file: common/fault_log_pkg.sv
package fault_log_pkg;

  // ==========================================================
  // Geometry and clock
  localparam int NUM_CH        = 6;
  localparam int CLK_PERIOD_NS = 8;

  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_SETUP_FIRST = 8'h0A;
  localparam logic [7:0] CMD_SETUP_LAST  = 8'h0F;
  localparam logic [7:0] CMD_HISTORY     = 8'h11;
  localparam logic [7:0] CMD_CLEAR       = 8'h1B;
  localparam logic [7:0] CMD_STORE       = 8'h1C;
  localparam logic [7:0] CMD_RESTORE     = 8'h1D;
  localparam logic [7:0] CMD_SNAPSHOT    = 8'h1E;
  localparam logic [7:0] CMD_LIVE        = 8'h1F;

  // ==========================================================
  // Channel setup word fields
  localparam int SETUP_POL_HI   = 7;
  localparam int SETUP_POL_LO   = 6;
  localparam int SETUP_HI_ROUTE = 3;
  localparam int SETUP_LO_ROUTE = 0;
  localparam logic [15:0] SETUP_USED_MASK = 16'h03FF;
  localparam logic [15:0] SETUP_RST_LOWER = 16'h0089;
  localparam logic [15:0] SETUP_RST_UPPER = 16'h0189;
  localparam int SETUP_UPPER_FIRST = 3;

  // ==========================================================
  // Fault words: flags in 12:1, reserved bits read zero
  localparam logic [15:0] WORD_FLAG_MASK = 16'h1FFE;
  localparam logic [15:0] WORD_RST       = 16'h0000;

  // ==========================================================
  // General input function codes
  localparam logic [2:0] FN_MANUAL_RESET = 3'h1;
  localparam logic [2:0] FN_MARGIN       = 3'h2;
  localparam logic [2:0] FN_UV_IGNORE    = 3'h3;

  // ==========================================================
  // Link address and rx byte index
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h5C;
  localparam logic [1:0] IDX_CMD          = 2'h0;
  localparam logic [1:0] IDX_DATA_LO      = 2'h1;
  localparam logic [1:0] IDX_DATA_HI      = 2'h2;

  // ==========================================================
  // Timing (longest times round down)
  localparam int CLEAR_TIME_NS    = 10_000_000;
  localparam int LOAD_TIME_NS     = 200_000;
  localparam int NV_WRITE_TIME_NS = 10_000_000;
  localparam int CLEAR_CYCLES_DEF    = CLEAR_TIME_NS / CLK_PERIOD_NS;
  localparam int LOAD_CYCLES_DEF     = LOAD_TIME_NS / CLK_PERIOD_NS;
  localparam int NV_WRITE_CYCLES_DEF = NV_WRITE_TIME_NS / CLK_PERIOD_NS;

  // ==========================================================
  // States
  typedef enum logic [2:0] {
    ST_BOOT, ST_READY, ST_CLEAR, ST_STORE, ST_LOAD, ST_SNAP
  } ctrl_state_e;

  typedef enum logic [1:0] {
    PH_ADDR, PH_WRITE, PH_READ, PH_IDLE
  } link_phase_e;

endpackage

// file: hdl/i2c_link.sv
`timescale 1ns/1ns
module i2c_link
  import fault_log_pkg::*;
(
  input  wire logic        scl,
  input  wire logic        link_rst_n,
  input  wire logic        por_n,
  input  wire logic        sda_in,
  input  wire logic [6:0]  dev_addr,
  input  wire logic        busy,
  input  wire logic [15:0] rd_word,
  output logic             sda_out,
  output logic             sda_oe,
  output logic [7:0]       rx_byte,
  output logic [1:0]       rx_idx,
  output logic             rx_tgl
);

  // ==========================================================
  // Bit engine on the host clock
  logic [3:0]  cnt_r;
  logic [7:0]  shift_r;
  link_phase_e phase_r;
  link_phase_e phase_nxt;
  logic        ack_r;
  logic        ack_nxt;
  logic        rd_go_r;
  logic        hi_r;
  logic [1:0]  wr_cnt_r;
  logic        busy_s1_r;
  logic        busy_s2_r;
  logic        oe_r;
  wire  [7:0]  byte_in   = {shift_r[6:0], sda_in};
  wire         byte_done = (cnt_r == 4'h7);
  wire         ack_slot  = (cnt_r == 4'h8);
  wire         addr_hit  = (byte_in[7:1] == dev_addr) && !busy_s2_r;
  wire         wr_byte   = byte_done && (phase_r == PH_WRITE);
  wire  [7:0]  tx_byte   = hi_r ? rd_word[15:8] : rd_word[7:0];
  wire         tx_bit    = tx_byte[3'(4'h7 - cnt_r)];

  // Phase and acknowledge decision at each byte end
  always_comb begin
    phase_nxt = phase_r;
    ack_nxt   = ack_r;
    if (byte_done) begin
      case (phase_r)
        PH_ADDR: begin
          ack_nxt   = addr_hit;
          phase_nxt = !addr_hit ? PH_IDLE : (byte_in[0] ? PH_READ : PH_WRITE);
        end
        PH_WRITE: ack_nxt = 1'b1;
        default:  ack_nxt = 1'b0;
      endcase
    end else if (ack_slot && phase_r == PH_READ && rd_go_r && sda_in) begin
      phase_nxt = PH_IDLE;                           // Host ended the read
    end
  end

  // Sampling edge
  always_ff @(posedge scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cnt_r     <= 4'h0;
      shift_r   <= 8'h00;
      phase_r   <= PH_ADDR;
      ack_r     <= 1'b0;
      rd_go_r   <= 1'b0;
      hi_r      <= 1'b0;
      wr_cnt_r  <= 2'h0;
      busy_s1_r <= 1'b0;
      busy_s2_r <= 1'b0;
    end else begin
      busy_s1_r <= busy;
      busy_s2_r <= busy_s1_r;
      shift_r   <= byte_in;
      cnt_r     <= ack_slot ? 4'h0 : cnt_r + 4'h1;
      phase_r   <= phase_nxt;
      ack_r     <= ack_nxt;
      if (ack_slot && phase_r == PH_READ) begin
        rd_go_r <= 1'b1;
        hi_r    <= rd_go_r ? ~hi_r : 1'b0;
      end
      if (wr_byte && wr_cnt_r != IDX_DATA_HI) begin
        wr_cnt_r <= wr_cnt_r + 2'h1;
      end
    end
  end

  // Received bytes; the toggle survives frame resets
  always_ff @(posedge scl or negedge por_n) begin
    if (!por_n) begin
      rx_byte <= 8'h00;
      rx_idx  <= IDX_CMD;
      rx_tgl  <= 1'b0;
    end else if (wr_byte) begin
      rx_byte <= byte_in;
      rx_idx  <= wr_cnt_r;
      rx_tgl  <= ~rx_tgl;
    end
  end

  // Drive edge: change the data line only while the clock is low
  always_ff @(negedge scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= (ack_slot && ack_r) ||
              (phase_r == PH_READ && rd_go_r && !ack_slot && !tx_bit);
    end
  end

  assign sda_oe  = oe_r;
  assign sda_out = 1'b0;

endmodule

// file: hdl/supply_fault_log_registers.sv
`timescale 1ns/1ns
// Function
// - Setup word bits 2,1,0 route low comparator to outputs 3,2,1; default 001.
// - Command 0x11 returns the two-byte latched fault history.
// - History is volatile; faults set latched bits that hold until cleared.
// - Command 0x1B clears every latched history bit.
// - Manual reset input clears history like 0x1B when its option is set.
// - Clearing history never touches the live fault word.
// - While a 0x1B history clear runs, the device acknowledges no transfer.
// - History bits 12:1 pair high/low flags per channel; 15:13 and 0 reserved.
// - 0x1C saves operating setup to nonvolatile; 0x1D reloads it.
// - Power-up loads nonvolatile contents as a reload does.
// - First fault writes the history word into nonvolatile as snapshot.
// - Later fault snapshot writes are blocked until a history clear re-arms them; 0x1C still writes the history.
// - Snapshot word has the same layout as the history word.
// - 0x1F returns the unlatched comparator state of the moment.
// - Margin or undervoltage-ignore inputs suppress faults in the live word.
// - High flag faults above threshold with polarity 1, below with 0.
// - Low flag faults below threshold with polarity 0, above with 1.
// - Undervoltage-ignore drops only undervoltage-type faults.
// - Margining drops both overvoltage and undervoltage faults.
// - Commands are ignored while any nonvolatile operation runs.
module supply_fault_log_registers
  import fault_log_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR        = DEV_ADDR_DEFAULT,
  parameter int         CLEAR_CYCLES    = CLEAR_CYCLES_DEF,
  parameter int         LOAD_CYCLES     = LOAD_CYCLES_DEF,
  parameter int         NV_WRITE_CYCLES = NV_WRITE_CYCLES_DEF
)(
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              scl,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  input  wire logic [NUM_CH-1:0] cmp_above_hi,
  input  wire logic [NUM_CH-1:0] cmp_above_lo,
  input  wire logic [1:0]        general_in_n,
  input  wire logic [2:0]        input1_function_select,
  input  wire logic [2:0]        input2_function_select,
  input  wire logic [1:0]        manual_reset_clears_log,
  output logic                   output_pin_1,
  output logic                   output_pin_2,
  output logic                   output_pin_3,
  output logic                   nv_busy
);

  // ==========================================================
  // Elaboration checks
  if (CLEAR_CYCLES < 1 || LOAD_CYCLES < 1 || NV_WRITE_CYCLES < 1) begin : g_bad_time
    $error("busy times must be at least one cycle");
  end

  // ==========================================================
  // Functions
  // Input pin active low and set up for the given function
  function automatic logic pin_active(input logic [2:0] fn,
                                      input logic [2:0] code,
                                      input logic       pin_n);
    pin_active = (fn == code) && !pin_n;
  endfunction

  // Factory setup word per channel; upper channels differ in range
  function automatic logic [15:0] setup_default(input int ch);
    setup_default = (ch < SETUP_UPPER_FIRST) ? SETUP_RST_LOWER : SETUP_RST_UPPER;
  endfunction

  // Comparator output to fault, per polarity bit
  function automatic logic fault_of(input logic above, input logic pol);
    fault_of = pol ? above : !above;
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic              scl_s1_r;
  logic              scl_s2_r;
  logic              scl_d_r;
  logic              sda_s1_r;
  logic              sda_s2_r;
  logic              sda_d_r;
  logic [1:0]        gpi_s1_r;
  logic [1:0]        gpi_s2_r;
  logic [NUM_CH-1:0] hi_s1_r;
  logic [NUM_CH-1:0] hi_s2_r;
  logic [NUM_CH-1:0] lo_s1_r;
  logic [NUM_CH-1:0] lo_s2_r;

  // Bus, general input and comparator pins pass two flops here; the link engine takes scl and sda_in unsynchronised
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r  <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r  <= 1'b1;
      gpi_s1_r <= 2'h3;
      gpi_s2_r <= 2'h3;
      hi_s1_r  <= '0;
      hi_s2_r  <= '0;
      lo_s1_r  <= '1;
      lo_s2_r  <= '1;
    end else begin
      scl_s1_r <= scl;
      scl_s2_r <= scl_s1_r;
      scl_d_r  <= scl_s2_r;
      sda_s1_r <= sda_in;
      sda_s2_r <= sda_s1_r;
      sda_d_r  <= sda_s2_r;
      gpi_s1_r <= general_in_n;
      gpi_s2_r <= gpi_s1_r;
      hi_s1_r  <= cmp_above_hi;
      hi_s2_r  <= hi_s1_r;
      lo_s1_r  <= cmp_above_lo;
      lo_s2_r  <= lo_s1_r;
    end
  end

  // ==========================================================
  // Frame framing: the link engine is held in reset outside frames.
  // Release happens with the host clock low, so no edge races it.
  logic link_run_r;
  logic armed_r;
  wire  scl_high   = scl_s2_r && scl_d_r;
  wire  start_cond = scl_high && sda_d_r && !sda_s2_r;
  wire  stop_cond  = scl_high && !sda_d_r && sda_s2_r;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      link_run_r <= 1'b0;
      armed_r    <= 1'b0;
    end else if (start_cond || stop_cond) begin
      link_run_r <= 1'b0;
      armed_r    <= start_cond;
    end else if (armed_r && !scl_s2_r) begin
      link_run_r <= 1'b1;
      armed_r    <= 1'b0;
    end
  end

  // ==========================================================
  // Link engine on the host clock
  logic [7:0]  rx_byte;
  logic [1:0]  rx_idx;
  logic        rx_tgl;
  logic [15:0] rd_word_r;

  i2c_link u_link (
    .scl        (scl),
    .link_rst_n (link_run_r),
    .por_n      (nrst),
    .sda_in     (sda_in),
    .dev_addr   (DEV_ADDR),
    .busy       (nv_busy),
    .rd_word    (rd_word_r),
    .sda_out    (sda_out),
    .sda_oe     (sda_oe),
    .rx_byte    (rx_byte),
    .rx_idx     (rx_idx),
    .rx_tgl     (rx_tgl)
  );

  // Byte event toggle crossing; byte and index hold still for
  // nine host clocks after the toggle, long past this sync
  logic tgl_s1_r;
  logic tgl_s2_r;
  logic tgl_d_r;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_d_r  <= 1'b0;
    end else begin
      tgl_s1_r <= rx_tgl;
      tgl_s2_r <= tgl_s1_r;
      tgl_d_r  <= tgl_s2_r;
    end
  end

  // ==========================================================
  // Live fault word
  logic [15:0]       setup_r    [NUM_CH];
  logic [15:0]       nv_setup_r [NUM_CH];
  logic [NUM_CH-1:0] hi_live;
  logic [NUM_CH-1:0] lo_live;
  logic [15:0]       live_w;

  // General input functions, either pin may serve
  wire margin_on = pin_active(input1_function_select, FN_MARGIN, gpi_s2_r[0]) ||
                   pin_active(input2_function_select, FN_MARGIN, gpi_s2_r[1]);
  wire uv_off_on = pin_active(input1_function_select, FN_UV_IGNORE, gpi_s2_r[0]) ||
                   pin_active(input2_function_select, FN_UV_IGNORE, gpi_s2_r[1]);
  wire mr_clear  =
    (pin_active(input1_function_select, FN_MANUAL_RESET, gpi_s2_r[0]) &&
     manual_reset_clears_log[0]) ||
    (pin_active(input2_function_select, FN_MANUAL_RESET, gpi_s2_r[1]) &&
     manual_reset_clears_log[1]);

  // Polarity 0 makes a flag undervoltage-type
  always_comb begin
    live_w = WORD_RST;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      hi_live[ch] = fault_of(hi_s2_r[ch], setup_r[ch][SETUP_POL_HI]) &&
                    !margin_on &&
                    !(uv_off_on && !setup_r[ch][SETUP_POL_HI]);
      lo_live[ch] = fault_of(lo_s2_r[ch], setup_r[ch][SETUP_POL_LO]) &&
                    !margin_on &&
                    !(uv_off_on && !setup_r[ch][SETUP_POL_LO]);
      live_w[2*ch+2] = hi_live[ch];
      live_w[2*ch+1] = lo_live[ch];
    end
  end

  // ==========================================================
  // Command control and nonvolatile sequencing
  ctrl_state_e state_r;
  ctrl_state_e state_nxt;
  logic [31:0] timer_r;
  logic [31:0] timer_nxt;
  logic [7:0]  cmd_r;
  logic [7:0]  data_lo_r;
  logic [15:0] hist_r;
  logic [15:0] op_snap_r;
  logic [15:0] nv_snap_r;
  logic        snap_armed_r;

  wire ready     = (state_r == ST_READY);
  wire rx_evt    = (tgl_s2_r != tgl_d_r) && ready;
  wire cmd_evt   = rx_evt && (rx_idx == IDX_CMD);
  wire clear_cmd = cmd_evt && (rx_byte == CMD_CLEAR);
  wire clear_any = clear_cmd || mr_clear;
  wire snap_go   = ready && !cmd_evt && snap_armed_r && (live_w != WORD_RST);
  wire load_done = (state_r == ST_BOOT || state_r == ST_LOAD) && (timer_r == 32'h0);
  wire [15:0] hist_nxt = ((clear_any ? WORD_RST : hist_r) | live_w) & WORD_FLAG_MASK;
  wire setup_hit = (cmd_r >= CMD_SETUP_FIRST) && (cmd_r <= CMD_SETUP_LAST);
  wire [2:0] setup_ch = 3'(cmd_r - CMD_SETUP_FIRST);

  // Next state: one command at a time, busy until the timer runs out
  always_comb begin
    state_nxt = state_r;
    timer_nxt = (timer_r != 32'h0) ? timer_r - 32'h1 : 32'h0;
    case (state_r)
      ST_READY: begin
        if (clear_cmd) begin
          state_nxt = ST_CLEAR;
          timer_nxt = 32'(CLEAR_CYCLES - 1);
        end else if (cmd_evt && rx_byte == CMD_STORE) begin
          state_nxt = ST_STORE;
          timer_nxt = 32'(NV_WRITE_CYCLES - 1);
        end else if (cmd_evt && rx_byte == CMD_RESTORE) begin
          state_nxt = ST_LOAD;
          timer_nxt = 32'(LOAD_CYCLES - 1);
        end else if (snap_go) begin
          state_nxt = ST_SNAP;
          timer_nxt = 32'(NV_WRITE_CYCLES - 1);
        end
      end
      default: begin
        if (timer_r == 32'h0) begin
          state_nxt = ST_READY;
        end
      end
    endcase
  end

  // Power-up starts in the load sequence
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_BOOT;
      timer_r <= 32'(LOAD_CYCLES - 1);
    end else begin
      state_r <= state_nxt;
      timer_r <= timer_nxt;
    end
  end

  // History: a new fault wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hist_r <= WORD_RST;
    end else begin
      hist_r <= hist_nxt;
    end
  end

  // Snapshot arm: one write per clear
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      snap_armed_r <= 1'b1;
    end else if (clear_any) begin
      snap_armed_r <= 1'b1;
    end else if (snap_go) begin
      snap_armed_r <= 1'b0;
    end
  end

  // Nonvolatile snapshot; store writes the history, so clear
  // then store leaves it empty
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      nv_snap_r <= WORD_RST;
    end else if (snap_go) begin
      nv_snap_r <= hist_nxt;
    end else if (cmd_evt && rx_byte == CMD_STORE) begin
      nv_snap_r <= hist_r;
    end
  end

  // Operating copy of the snapshot, refreshed by every load
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      op_snap_r <= WORD_RST;
    end else if (load_done) begin
      op_snap_r <= nv_snap_r & WORD_FLAG_MASK;
    end
  end

  // Command byte and low data byte
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cmd_r     <= 8'h00;
      data_lo_r <= 8'h00;
    end else if (cmd_evt) begin
      cmd_r <= rx_byte;
    end else if (rx_evt && rx_idx == IDX_DATA_LO) begin
      data_lo_r <= rx_byte;
    end
  end

  // ==========================================================
  // Setup words: operating and nonvolatile copies
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        setup_r[ch] <= setup_default(ch);
      end
    end else if (load_done) begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        setup_r[ch] <= nv_setup_r[ch];
      end
    end else if (rx_evt && rx_idx == IDX_DATA_HI && setup_hit) begin
      setup_r[setup_ch] <= {rx_byte, data_lo_r} & SETUP_USED_MASK;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        nv_setup_r[ch] <= setup_default(ch);
      end
    end else if (cmd_evt && rx_byte == CMD_STORE) begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        nv_setup_r[ch] <= setup_r[ch];
      end
    end
  end

  // ==========================================================
  // Read word, captured when the command byte lands. It stays
  // still through the ack and restart, so the link may read it.
  logic [15:0] rd_sel;

  always_comb begin
    if (rx_byte == CMD_HISTORY) begin
      rd_sel = hist_r;
    end else if (rx_byte == CMD_SNAPSHOT) begin
      rd_sel = op_snap_r;
    end else if (rx_byte == CMD_LIVE) begin
      rd_sel = live_w;
    end else if (rx_byte >= CMD_SETUP_FIRST && rx_byte <= CMD_SETUP_LAST) begin
      rd_sel = setup_r[3'(rx_byte - CMD_SETUP_FIRST)];
    end else begin
      rd_sel = WORD_RST;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_word_r <= WORD_RST;
    end else if (cmd_evt) begin
      rd_word_r <= rd_sel;
    end
  end

  // ==========================================================
  // Fault routing onto the outputs (one register stage, no polarity stage)
  logic [2:0] route_r;
  logic [2:0] route_w;

  always_comb begin
    route_w = 3'h0;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      for (int k = 0; k < 3; k++) begin
        route_w[k] = route_w[k] ||
                     (lo_live[ch] && setup_r[ch][SETUP_LO_ROUTE + k]) ||
                     (hi_live[ch] && setup_r[ch][SETUP_HI_ROUTE + k]);
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      route_r <= 3'h0;
    end else begin
      route_r <= route_w;
    end
  end

  assign output_pin_1 = route_r[0];
  assign output_pin_2 = route_r[1];
  assign output_pin_3 = route_r[2];
  assign nv_busy      = !ready;

endmodule

// file: tb/fault_log_props.sv
`timescale 1ns/1ns
module fault_log_props
  import fault_log_pkg::*;
#(parameter int LOAD_CYCLES = LOAD_CYCLES_DEF)(
  input wire logic              mclk,
  input wire logic              nrst,
  input wire logic              sda_oe,
  input wire logic [NUM_CH-1:0] cmp_above_hi,
  input wire logic [NUM_CH-1:0] cmp_above_lo,
  input wire logic [1:0]        general_in_n,
  input wire logic              output_pin_1,
  input wire logic              output_pin_2,
  input wire logic              output_pin_3,
  input wire logic              nv_busy
);
  int boot_cnt;
  int busy_cnt;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ==========
  // Run lengths of boot and busy, saturating so they never wrap
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst) boot_cnt <= 0;
    else if (boot_cnt < LOAD_CYCLES) boot_cnt <= boot_cnt + 1;
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst) busy_cnt <= 0;
    else busy_cnt <= nv_busy ? (busy_cnt < 63 ? busy_cnt + 1 : 63) : 0;
  // ==========
  // Boot, busy spans, refusals, routing
  boot_busy_a: assert property (boot_cnt < LOAD_CYCLES - 2 |-> nv_busy)
    else $error("busy low in boot");
  boot_end_a: assert property (boot_cnt == LOAD_CYCLES - 1 |-> ##[0:8] !nv_busy)
    else $error("boot too long");
  busy_span_a: assert property ($rose(nv_busy) |-> nv_busy[*8])
    else $error("busy too short");
  // Slack of 32 covers an ack slot already under way
  busy_nack_a: assert property (busy_cnt > 32 |-> !sda_oe)
    else $error("ack while busy");
  route_def_a: assert property (!output_pin_2 && !output_pin_3)
    else $error("pin 2 or 3 driven");
  hi_out_a: assert property (
    (cmp_above_hi != '0 && general_in_n == 2'b11)[*6] |-> output_pin_1)
    else $error("high fault missing");
  lo_out_a: assert property (
    (cmp_above_lo != '1 && general_in_n == 2'b11)[*6] |-> output_pin_1)
    else $error("low fault missing");
  quiet_out_a: assert property (
    (cmp_above_hi == '0 && cmp_above_lo == '1)[*6] |-> !output_pin_1)
    else $error("pin 1 without fault");
endmodule
bind supply_fault_log_registers fault_log_props #(.LOAD_CYCLES(LOAD_CYCLES)) fault_log_props_i (
  .mclk(mclk), .nrst(nrst), .sda_oe(sda_oe), .cmp_above_hi(cmp_above_hi),
  .cmp_above_lo(cmp_above_lo), .general_in_n(general_in_n), .output_pin_1(output_pin_1),
  .output_pin_2(output_pin_2), .output_pin_3(output_pin_3), .nv_busy(nv_busy));

// file: tb/i2c_host_model.sv
`timescale 1ns/1ns
module i2c_host_model
  import fault_log_pkg::*;
(
  input  wire logic  sda_oe,
  output logic       scl,
  output logic       sda,
  output logic [15:0] word
);
  logic drv = 1'b1;
  event got;
  initial scl = 1'b1;
  // Pulled-up wire: released means high, never the last value
  assign sda = drv & ~sda_oe;
  // Eight bits plus ack slot, 64 ns bit time
  task automatic xb(input logic [8:0] o, output logic [8:0] i);
    for (int k = 8; k >= 0; k--) begin
      drv = o[k];
      #16 scl = 1'b1;
      #32 i[k] = sda;
      scl = 1'b0;
      #16;
    end
    #128;
  endtask
  // Clock held low after start: the engine leaves reset some mclk cycles
  // after the first low clock, and an early rising edge would be lost
  task automatic st;
    #32 drv = 1'b0;
    #32 scl = 1'b0;
    #32;
  endtask
  task automatic sp;
    drv = 1'b0;
    #16 scl = 1'b1;
    #32 drv = 1'b1;
    #32;
  endtask
  // ==========
  // Whole transfer; a refused address is retried, not fatal
  task automatic go(input logic [7:0] c, input logic rd);
    logic [8:0] i;
    logic [7:0] lo;
    for (int t = 0; t < 200; t++) begin
      st;
      xb({DEV_ADDR_DEFAULT, 2'b01}, i);
      if (!i[0]) break;
      sp;
      #200;
    end
    xb({c, 1'b1}, i);
    if (rd) begin
      drv = 1'b1;
      #16 scl = 1'b1;
      st;
      xb({DEV_ADDR_DEFAULT, 2'b11}, i);
      xb(9'h1FE, i);
      lo = i[8:1];
      xb(9'h1FF, i);
      word = {i[8:1], lo};
      ->got;
    end
    sp;
  endtask
endmodule

// file: tb/supply_fault_log_registers_tb_top.sv
`timescale 1ns/1ns
module supply_fault_log_registers_tb_top
  import fault_log_pkg::*;
;
  logic        mclk = 1'b0, nrst = 1'b0, scl, sda, sda_oe;
  logic [5:0]  hi = 6'h00, lo = 6'h3F;
  logic [1:0]  gin_n = 2'b11;
  logic [2:0]  pins;
  logic [2:0]  f1 = FN_MARGIN;
  logic [15:0] rd_w, acc = 16'h0000, first_w = 16'h0000, exp_q[$];
  logic [31:0] rng = 32'h4E;
  int          err_total = 0, checks = 0;
  always #4 mclk = ~mclk;
  supply_fault_log_registers #(.CLEAR_CYCLES(200), .LOAD_CYCLES(100), .NV_WRITE_CYCLES(200))
    supply_fault_log_registers_i (.mclk(mclk), .nrst(nrst), .scl(scl), .sda_in(sda),
    .sda_out(), .sda_oe(sda_oe), .cmp_above_hi(hi), .cmp_above_lo(lo),
    .general_in_n(gin_n), .input1_function_select(f1),
    .input2_function_select(FN_MANUAL_RESET), .manual_reset_clears_log(2'b10),
    .output_pin_1(pins[0]), .output_pin_2(pins[1]), .output_pin_3(pins[2]), .nv_busy());
  i2c_host_model i2c_host_model_i (.sda_oe(sda_oe), .scl(scl), .sda(sda), .word(rd_w));
  // ==========
  // Expected live word, default polarities; m[1] margin, m[0] low flags ignored
  function automatic logic [15:0] live(input logic [5:0] h, l, input logic [1:0] m);
    logic [15:0] w;
    w = 16'h0000;
    for (int c = 0; c < 6; c++) begin
      w[2*c+2] = h[c] & !m[1];
      w[2*c+1] = !l[c] & (m == 2'b00);
    end
    return w;
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    exp_q.push_back(e);
    i2c_host_model_i.go(c, 1'b1);
  endtask
  task automatic setf(input logic [5:0] h, l, input logic [1:0] g);
    @(posedge mclk);
    hi <= h;
    lo <= l;
    gin_n <= g;
    repeat (4) @(posedge mclk);
  endtask
  task automatic chk_word(input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD word exp %h got %h", e, g);
    end
  endtask
  task automatic chk_pins(input logic [2:0] e, g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD pins exp %h got %h", e, g);
    end
  endtask
  task automatic summarize;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Oldest note against each word read back
  always @(i2c_host_model_i.got) chk_word(exp_q.pop_front(), rd_w);
  initial begin
    #400_000;
    err_total++;
    summarize;
  end
  // ==========
  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    rd(CMD_HISTORY, 16'h0000);
    rd(CMD_SNAPSHOT, 16'h0000);
    repeat (4) begin
      rng = xs(rng);
      setf(rng[5:0], rng[13:8], 2'b11);
      chk_pins({2'b00, |live(rng[5:0], rng[13:8], 2'b00)}, pins);
      rd(CMD_LIVE, live(rng[5:0], rng[13:8], 2'b00));
      acc = acc | live(rng[5:0], rng[13:8], 2'b00);
      if (first_w == 16'h0000) first_w = acc;
    end
    setf(6'h00, 6'h3F, 2'b11);
    rd(CMD_HISTORY, acc);
    i2c_host_model_i.go(CMD_RESTORE, 1'b0);
    rd(CMD_SNAPSHOT, first_w);
    setf(6'h00, 6'h3F, 2'b01);
    setf(6'h00, 6'h3F, 2'b11);
    rd(CMD_HISTORY, 16'h0000);
    setf(6'h15, 6'h2A, 2'b10);
    rd(CMD_LIVE, 16'h0000);
    @(posedge mclk) f1 <= FN_UV_IGNORE;
    rd(CMD_LIVE, live(6'h15, 6'h2A, 2'b01));
    setf(6'h15, 6'h2A, 2'b11);
    i2c_host_model_i.go(CMD_CLEAR, 1'b0);
    rd(CMD_LIVE, live(6'h15, 6'h2A, 2'b00));
    setf(6'h00, 6'h3F, 2'b11);
    i2c_host_model_i.go(CMD_CLEAR, 1'b0);
    i2c_host_model_i.go(CMD_STORE, 1'b0);
    i2c_host_model_i.go(CMD_RESTORE, 1'b0);
    rd(CMD_SNAPSHOT, 16'h0000);
    rd(CMD_HISTORY, 16'h0000);
    summarize;
  end
endmodule
